// ==== hdl/dma_arbiter.sv ====
/*
  Channel arbiter: priority levels, fairness slots, round robin.
  Assumes: requests come from logic on the same clock; take_i pulses
  once per finished bus transaction of the granted channel.
*/
`timescale 1ns/1ps
module dma_arbiter #(
  parameter int N = 24
) (
  input  wire logic               clk_i,
  input  wire logic               reset_n_i,
  input  wire logic [N-1:0]       req_i,
  input  wire logic [N-1:0][2:0]  prio_i,
  input  wire logic [N-1:0]       rr_dis_i,
  input  wire logic               fair_en_i,
  input  wire logic               take_i,
  input  wire logic [4:0]         take_idx_i,
  input  wire logic [2:0]         take_lvl_i,
  output logic                    gnt_valid_o,
  output logic [4:0]              gnt_idx_o
);
  if (N < 2 || N > 32) begin : g_bad_n
    $error("dma_arbiter: N out of range");
  end

  dma_pkg::arb_state_t s;
  dma_pkg::arb_state_t next_s;
  logic [7:0] has;
  logic [2:0] lvl;
  logic [2:0] fl;
  logic       pin;
  int         j;

  // ----------------------------------------------------------------
  // selection
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    has = '0;
    lvl = '0;
    fl = 3'h7;
    pin = 1'b0;
    j = 0;
    gnt_idx_o = '0;
    for (int i = 0; i < N; i++) begin
      if (req_i[i]) has[prio_i[i]] = 1'b1;
    end
    // strict: smallest number wins
    for (int l = 7; l >= 0; l--) begin
      if (has[l]) lvl = 3'(l);
    end
    // slot owner: level 2 every 2nd, level 3 every 4th, ...
    for (int b = 4; b >= 0; b--) begin
      if (s.slot[b]) fl = 3'(b + 2);
    end
    // levels 0 and 1 never yield their slots
    if (fair_en_i && !has[0] && !has[1] && has[fl]) lvl = fl;
    // a channel out of the rotation heads its level
    for (int i = N - 1; i >= 0; i--) begin
      if (req_i[i] && prio_i[i] == lvl && rr_dis_i[i]) begin
        gnt_idx_o = 5'(i);
        pin = 1'b1;
      end
    end
    // otherwise first requester after the level pointer
    if (!pin) begin
      for (int k = N - 1; k >= 0; k--) begin
        j = int'(s.ptr[lvl]) + 1 + k;
        if (j >= N) j = j - N;
        if (req_i[j] && prio_i[j] == lvl) gnt_idx_o = 5'(j);
      end
    end
    gnt_valid_o = |has;
    if (take_i) begin
      next_s.ptr[take_lvl_i] = take_idx_i;
      next_s.slot = s.slot + 7'h01;
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) s <= '0;
    else s <= next_s;
  end
endmodule : dma_arbiter

// ==== hdl/dma_cfg.svh ====
/*
  Constants of the DMA channel engine: register offsets, field
  positions, reset values and timing counts.
  Assumes: included by bare name; definitions only.
*/
`ifndef DMA_CFG_SVH
`define DMA_CFG_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define CH_NUM          24
`define TD_NUM          128
`define PRIO_LEVELS     8

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define OFS_CTRL        12'h000
`define OFS_STATUS      12'h004
`define OFS_SWTRIG      12'h008
`define OFS_RUNMASK     12'h00C
`define OFS_CHCFG_PAGE  4'h1
`define OFS_POOL_BIT    11

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define CTRL_EN_BIT     0
`define CTRL_FAIR_BIT   1
`define CTRL_RST        2'h0
`define COUNT_INF       17'h00000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_MHZ         40
`define STARVE_NS       500
`define STARVE_CYC      (((`STARVE_NS) * (`CLK_MHZ) + 999) / 1000)

`endif

// ==== hdl/dma_channel_arbiter_chainer.sv ====
/*
  Multi-channel DMA engine: descriptor pool, channel triggers,
  chaining, stall and abort, byte mover on the peripheral hub bus,
  APB register slave.
  Assumes: one clock; routed triggers are asynchronous; the hub bus
  answers each request with a one-cycle ack; the CPU shares the hub.
*/
// Implementation choices: register access over APB and the placing of the registers.
// Function
// - channels draw descriptors from one 128-entry pool
// - descriptors editable live, later links see edits
// - eight priority levels, zero most urgent
// - start by routed signal, CPU, or channel
// - two interrupt pulses per transfer, half and done
// - pause resumes later, cancel aborts early
// - length one byte to 131071 or endless
// - finished descriptor continues with linked one
// - CPU wins shared spoke, DMA never starved
// - urgent channel preempts only between bus transactions
// - levels zero and one skip fairness entirely
// - fairness slots give level two half, halving
// - equal level ties rotate round robin
// - rotation disable makes channel head its level
// - fairness off means strict priority only
// - one descriptor moves source to sink
// - descriptor may link to itself, repeats
// - two descriptors linking each other ping-pong
// - ring of descriptors returns to first
// - each chained descriptor holds its own segment
// - config, data, status subchains chain together
// - arbiter grants most urgent pending channel, except where a fairness slot applies
// - CPU and DMA on different spokes concurrent
`timescale 1ns/1ps
`include "dma_cfg.svh"
module dma_channel_arbiter_chainer #(
  parameter int N_CH = 24,
  parameter int N_TD = 128
) (
  input  wire logic                     clk_i,
  input  wire logic                     reset_n_i,
  input  wire logic                     psel_i,
  input  wire logic                     penable_i,
  input  wire logic                     pwrite_i,
  input  wire logic [11:0]              paddr_i,
  input  wire logic [31:0]              pwdata_i,
  output logic      [31:0]              prdata_o,
  output logic                          pready_o,
  output logic                          pslverr_o,
  input  wire logic [`CH_NUM-1:0]       trig_i,
  input  wire logic                     cpu_req_i,
  input  wire logic [2:0]               cpu_spoke_i,
  output dma_pkg::hub_req_t             hub_o,
  input  wire logic                     hub_ack_i,
  input  wire logic [7:0]               hub_rdata_i,
  output logic      [`CH_NUM-1:0]       evt_done_o,
  output logic      [`CH_NUM-1:0]       evt_half_o
);
  if (N_CH < 2 || N_CH > `CH_NUM || N_TD < 1 || N_TD > `TD_NUM) begin : g_bad
    $error("dma_channel_arbiter_chainer: size parameter out of range");
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  dma_pkg::top_state_t s;
  dma_pkg::top_state_t next_s;
  logic [`CH_NUM-1:0]      arb_req;
  logic [`CH_NUM-1:0][2:0] arb_prio;
  logic [`CH_NUM-1:0]      arb_rr;
  logic [`CH_NUM-1:0]      run_v;
  logic [`CH_NUM-1:0]      edge_v;
  logic                    gnt_valid;
  logic [4:0]              gnt_idx;
  logic                    take;

  // pool entry turned into fresh channel progress
  function automatic dma_pkg::chan_run_t load_td(input dma_pkg::desc_t p,
                                                 input logic [6:0] idx);
    dma_pkg::chan_run_t r;
    r.run = 1'b1;
    r.td  = idx;
    r.src = p.src;
    r.dst = p.dst;
    r.rem = p.count;
    r.inf = (p.count == `COUNT_INF);
    return r;
  endfunction : load_td

  // ----------------------------------------------------------------
  // per-channel arbiter inputs
  // ----------------------------------------------------------------
  for (genvar g = 0; g < `CH_NUM; g++) begin : g_ch
    // only idle engine arbitrates, so a grant never cuts a transaction
    assign arb_req[g]  = (g < N_CH) && s.ch[g].run && s.cfg[g].enable
                         && !s.cfg[g].pause && !s.cfg[g].cancel
                         && s.ctrl[`CTRL_EN_BIT]
                         && s.eng == dma_pkg::ENG_IDLE;
    assign arb_prio[g] = s.cfg[g].prio;
    assign arb_rr[g]   = s.cfg[g].rr_dis;
    assign run_v[g]    = s.ch[g].run;
    // rising edge seen on synchronised copies only
    assign edge_v[g]   = s.tsync[1][g] & ~s.tsync[2][g];
  end

  dma_arbiter #(
    .N (`CH_NUM)
  ) u_arb (
    .clk_i      (clk_i),
    .reset_n_i  (reset_n_i),
    .req_i      (arb_req),
    .prio_i     (arb_prio),
    .rr_dis_i   (arb_rr),
    .fair_en_i  (s.ctrl[`CTRL_FAIR_BIT]),
    .take_i     (take),
    .take_idx_i (s.cur),
    .take_lvl_i (s.cfg[s.cur].prio),
    .gnt_valid_o(gnt_valid),
    .gnt_idx_o  (gnt_idx)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [`CH_NUM-1:0] trig;
    logic [`CH_NUM-1:0] sw;
    logic               acc;
    logic               hit;
    logic               wr;
    logic               blocked;
    logic               last;
    logic [31:0]        rd;
    logic [4:0]         ci;
    logic [6:0]         ti;
    logic [4:0]         c;
    dma_pkg::chan_run_t nr;
    dma_pkg::desc_t     d;
    trig = '0;
    sw = '0;
    acc = psel_i & penable_i;
    hit = 1'b0;
    rd = '0;
    ci = paddr_i[6:2];
    ti = paddr_i[10:4];
    c = s.cur;
    nr = s.ch[s.cur];
    d = s.pool[s.ch[s.cur].td];
    last = 1'b0;
    take = 1'b0;
    wr = 1'b0;
    blocked = cpu_req_i && cpu_spoke_i == s.hub.addr[15:13];
    next_s = s;
    next_s.done = '0;
    next_s.half = '0;
    next_s.fin = '0;
    // two-flop synchroniser, third flop for the edge
    next_s.tsync = {s.tsync[1:0], trig_i};

    // register decode; misaligned or out-of-range is an error
    if (paddr_i[1:0] == 2'h0) begin
      if (paddr_i == `OFS_CTRL) begin
        hit = 1'b1;
        rd = {30'h0, s.ctrl};
      end else if (paddr_i == `OFS_STATUS) begin
        hit = 1'b1;
        rd = {26'h0, s.cur, s.eng != dma_pkg::ENG_IDLE};
      end else if (paddr_i == `OFS_SWTRIG) begin
        hit = 1'b1;
      end else if (paddr_i == `OFS_RUNMASK) begin
        hit = 1'b1;
        rd = {8'h00, run_v};
      end else if (paddr_i[11:8] == `OFS_CHCFG_PAGE && !paddr_i[7]
                   && int'(ci) < N_CH) begin
        hit = 1'b1;
        rd = {11'h000, s.cfg[ci]};
      end else if (paddr_i[`OFS_POOL_BIT] && int'(ti) < N_TD) begin
        hit = 1'b1;
        case (paddr_i[3:2])
          2'h0:    rd = {16'h0000, s.pool[ti].src};
          2'h1:    rd = {16'h0000, s.pool[ti].dst};
          2'h2:    rd = {15'h0000, s.pool[ti].count};
          default: rd = {20'h00000, s.pool[ti].dst_inc, s.pool[ti].src_inc,
                         s.pool[ti].irq_half, s.pool[ti].irq_done,
                         s.pool[ti].chain, s.pool[ti].next};
        endcase
      end
    end
    wr = acc & s.pready & pwrite_i & hit;
    if (wr && paddr_i == `OFS_SWTRIG) sw = pwdata_i[`CH_NUM-1:0];

    // trigger sources of every channel
    for (int i = 0; i < N_CH; i++) begin
      trig[i] = s.cfg[i].enable & (sw[i] | (s.cfg[i].trig_en & edge_v[i])
                | (s.cfg[i].chain_en & s.fin[s.cfg[i].chain_src]));
    end

    // byte mover: read source, then write sink
    case (s.eng)
      dma_pkg::ENG_IDLE: begin
        if (gnt_valid) begin
          next_s.cur = gnt_idx;
          next_s.hub.we = 1'b0;
          next_s.hub.addr = s.ch[gnt_idx].src;
          next_s.wait_cnt = '0;
          next_s.eng = dma_pkg::ENG_READ;
        end
      end
      dma_pkg::ENG_READ, dma_pkg::ENG_WRITE: begin
        if (!s.hub.req) begin
          // CPU on the same spoke goes first, but only so long
          if (!blocked || s.wait_cnt == 5'(`STARVE_CYC)) begin
            next_s.hub.req = 1'b1;
            next_s.wait_cnt = '0;
          end else begin
            next_s.wait_cnt = s.wait_cnt + 5'h01;
          end
        end else if (hub_ack_i) begin
          next_s.hub.req = 1'b0;
          if (s.eng == dma_pkg::ENG_READ) begin
            next_s.hub.we = 1'b1;
            next_s.hub.addr = s.ch[c].dst;
            next_s.hub.wdata = hub_rdata_i;
            next_s.eng = dma_pkg::ENG_WRITE;
          end else begin
            next_s.hub.we = 1'b0;
            next_s.eng = dma_pkg::ENG_IDLE;
            take = 1'b1;
          end
        end
      end
      default: next_s.eng = dma_pkg::ENG_IDLE;
    endcase

    // progress after a finished byte; each descriptor has own segment
    if (take) begin
      if (d.src_inc) nr.src = s.ch[c].src + 16'h0001;
      if (d.dst_inc) nr.dst = s.ch[c].dst + 16'h0001;
      if (!s.ch[c].inf) nr.rem = s.ch[c].rem - 17'h00001;
      last = !s.ch[c].inf && s.ch[c].rem == 17'h00001;
      if (d.irq_half && !s.ch[c].inf && d.count > 17'h00001
          && nr.rem == {1'b0, d.count[16:1]}) begin
        next_s.half[c] = 1'b1;
      end
      if (last) begin
        if (d.irq_done) next_s.done[c] = 1'b1;
        if (d.chain) begin
          // successor read now from the pool, so edits count
          // self, pair or ring links all use this path
          // packet phases are plain links too
          nr = load_td(s.pool[d.next], d.next);
        end else begin
          next_s.fin[c] = 1'b1;
          // a trigger in the finishing cycle restarts, not lost
          nr = trig[c] ? load_td(s.pool[s.cfg[c].first_td], s.cfg[c].first_td)
                       : '0;
        end
      end
      // abort lands on the transaction boundary
      if (s.cfg[c].cancel) begin
        nr.run = 1'b0;
        next_s.cfg[c].cancel = 1'b0;
      end
      next_s.ch[c] = nr;
    end

    // idle channels start; a trigger while running is ignored except in the finishing cycle
    for (int i = 0; i < N_CH; i++) begin
      if (trig[i] && !s.ch[i].run) begin
        next_s.ch[i] = load_td(s.pool[s.cfg[i].first_td], s.cfg[i].first_td);
      end
      if (s.cfg[i].cancel && !(s.eng != dma_pkg::ENG_IDLE && int'(c) == i)) begin
        next_s.ch[i].run = 1'b0;
        next_s.cfg[i].cancel = 1'b0;
      end
    end

    // APB: pready one cycle into access, write lands on the pready edge
    if (acc && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.prdata = rd;
      next_s.pslverr = ~hit;
    end else begin
      next_s.pready = 1'b0;
      next_s.pslverr = 1'b0;
    end
    if (wr) begin
      if (paddr_i == `OFS_CTRL) begin
        next_s.ctrl = pwdata_i[1:0];
      end else if (paddr_i[11:8] == `OFS_CHCFG_PAGE) begin
        next_s.cfg[ci] = dma_pkg::chan_cfg_t'(pwdata_i[20:0]);
      end else if (paddr_i[`OFS_POOL_BIT]) begin
        // pool stays writable while channels run
        case (paddr_i[3:2])
          2'h0:    next_s.pool[ti].src = pwdata_i[15:0];
          2'h1:    next_s.pool[ti].dst = pwdata_i[15:0];
          2'h2:    next_s.pool[ti].count = pwdata_i[16:0];
          default: {next_s.pool[ti].dst_inc, next_s.pool[ti].src_inc,
                    next_s.pool[ti].irq_half, next_s.pool[ti].irq_done,
                    next_s.pool[ti].chain, next_s.pool[ti].next}
                     = pwdata_i[11:0];
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= '0;
      s.ctrl <= `CTRL_RST;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state flops
  assign prdata_o   = s.prdata;
  assign pready_o   = s.pready;
  assign pslverr_o  = s.pslverr;
  assign hub_o      = s.hub;
  assign evt_done_o = s.done;
  assign evt_half_o = s.half;
endmodule : dma_channel_arbiter_chainer

// ==== hdl/dma_pkg.sv ====
/*
  Types of the DMA channel engine.
  Assumes: dma_cfg.svh is on the include path.
*/
package dma_pkg;
  `include "dma_cfg.svh"

  typedef enum logic [1:0] {ENG_IDLE, ENG_READ, ENG_WRITE} eng_state_t;

  // one descriptor of the shared pool
  typedef struct packed {
    logic [15:0] src;
    logic [15:0] dst;
    logic [16:0] count;
    logic        dst_inc;
    logic        src_inc;
    logic        irq_half;
    logic        irq_done;
    logic        chain;
    logic [6:0]  next;
  } desc_t;

  // software settings of one channel, low bits of its register
  typedef struct packed {
    logic [4:0]  chain_src;
    logic        chain_en;
    logic        trig_en;
    logic [6:0]  first_td;
    logic        cancel;
    logic        pause;
    logic        enable;
    logic        rr_dis;
    logic [2:0]  prio;
  } chan_cfg_t;

  // live progress of one channel
  typedef struct packed {
    logic        run;
    logic [6:0]  td;
    logic [15:0] src;
    logic [15:0] dst;
    logic [16:0] rem;
    logic        inf;
  } chan_run_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } hub_req_t;

  typedef struct packed {
    logic [`PRIO_LEVELS-1:0][4:0] ptr;
    logic [6:0]                   slot;
  } arb_state_t;

  typedef struct packed {
    desc_t     [`TD_NUM-1:0] pool;
    chan_cfg_t [`CH_NUM-1:0] cfg;
    chan_run_t [`CH_NUM-1:0] ch;
    logic      [1:0]         ctrl;
    eng_state_t              eng;
    logic      [4:0]         cur;
    hub_req_t                hub;
    logic      [4:0]         wait_cnt;
    logic [2:0][`CH_NUM-1:0] tsync;
    logic      [`CH_NUM-1:0] done;
    logic      [`CH_NUM-1:0] half;
    logic      [`CH_NUM-1:0] fin;
    logic                    pready;
    logic                    pslverr;
    logic      [31:0]        prdata;
  } top_state_t;
endpackage : dma_pkg

// ==== testbench/dma_channel_arbiter_chainer_checker.sv ====
/*
  Port checker of the DMA engine: APB answer timing, hub request
  holding and byte order, event pulses.
  Assumes: bound to the engine top; dma_cfg.svh on the include path.
*/
`timescale 1ns/1ps
`include "dma_cfg.svh"
module dma_channel_arbiter_chainer_checker #(
  parameter int N_CH = 24,
  parameter int N_TD = 128
) (
  input wire logic                 clk_i,
  input wire logic                 reset_n_i,
  input wire logic                 psel_i,
  input wire logic                 penable_i,
  input wire logic                 pwrite_i,
  input wire logic [11:0]          paddr_i,
  input wire logic [31:0]          pwdata_i,
  input wire logic [31:0]          prdata_o,
  input wire logic                 pready_o,
  input wire logic                 pslverr_o,
  input wire logic [`CH_NUM-1:0]   trig_i,
  input wire logic                 cpu_req_i,
  input wire logic [2:0]           cpu_spoke_i,
  input wire dma_pkg::hub_req_t    hub_o,
  input wire logic                 hub_ack_i,
  input wire logic [7:0]           hub_rdata_i,
  input wire logic [`CH_NUM-1:0]   evt_done_o,
  input wire logic [`CH_NUM-1:0]   evt_half_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // ----------------------------------------------------------------
  // sequences and properties
  // ----------------------------------------------------------------
  // accepted hub bytes, split by direction
  wire logic rd_ack = hub_o.req && hub_ack_i && !hub_o.we;
  wire logic wr_ack = hub_o.req && hub_ack_i && hub_o.we;
  sequence s_setup;  psel_i && !penable_i; endsequence
  sequence s_access; psel_i && penable_i;  endsequence
  property p_ready_wait;  s_setup ##1 s_access |-> !pready_o ##1 pready_o; endproperty
  property p_ready_pulse; pready_o |=> !pready_o; endproperty
  property p_ready_cause; pready_o |-> s_access and $past(penable_i); endproperty
  property p_err_zero;    pslverr_o |-> pready_o && prdata_o == 32'h0; endproperty
  property p_hub_hold;    hub_o.req && !hub_ack_i |=> hub_o.req && $stable(hub_o); endproperty
  property p_rd_then_wr;  rd_ack |=> !hub_o.req && hub_o.we ##[1:21] hub_o.req; endproperty
  property p_wr_gap;      wr_ack |=> !hub_o.req [*2]; endproperty
  property p_done_cause;  |evt_done_o |-> $past(wr_ack); endproperty
  property p_half_cause;  |evt_half_o |-> $past(wr_ack); endproperty
  property p_done_pulse;  |evt_done_o |=> evt_done_o == '0; endproperty
  a_ready_wait:  assert property (p_ready_wait)  else $error("apb answer not after one wait");
  a_ready_pulse: assert property (p_ready_pulse) else $error("apb ready longer than a cycle");
  a_ready_cause: assert property (p_ready_cause) else $error("apb ready outside access");
  a_err_zero:    assert property (p_err_zero)    else $error("error answer with data");
  a_hub_hold:    assert property (p_hub_hold)    else $error("hub request changed early");
  a_rd_then_wr:  assert property (p_rd_then_wr)  else $error("read byte not written");
  a_wr_gap:      assert property (p_wr_gap)      else $error("no gap after byte");
  a_done_cause:  assert property (p_done_cause)  else $error("done event without byte");
  a_half_cause:  assert property (p_half_cause)  else $error("half event without byte");
  a_done_pulse:  assert property (p_done_pulse)  else $error("done event too long");
endmodule : dma_channel_arbiter_chainer_checker

bind dma_channel_arbiter_chainer dma_channel_arbiter_chainer_checker
  #(.N_CH(N_CH), .N_TD(N_TD)) u_chk (.clk_i, .reset_n_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .trig_i,
  .cpu_req_i, .cpu_spoke_i, .hub_o, .hub_ack_i, .hub_rdata_i, .evt_done_o,
  .evt_half_o);

// ==== testbench/dma_channel_arbiter_chainer_tb.sv ====
/*
  Bench of the DMA engine: APB master, CPU noise, hub memory and a
  byte queue model of each transfer.
  Assumes: engine, checker and hub memory model compiled first.
*/
`timescale 1ns/1ps
module dma_channel_arbiter_chainer_tb;
  logic clk_i = 1'b0, reset_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic pready_o, pslverr_o, cpu_req_i = 1'b0, hub_ack_i, er;
  logic [23:0] trig_i = 24'h0, evt_done_o, evt_half_o;
  logic [2:0] cpu_spoke_i = 3'h0;
  logic [7:0] hub_rdata_i, exp_q [$];
  dma_pkg::hub_req_t hub_o;
  int n_mismatch = 0, cmp_count = 0, n_half = 0, cnt;
  logic [11:0] ra [6] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h002};
  logic re [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};

  dma_channel_arbiter_chainer dut (.clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .trig_i, .cpu_req_i,
    .cpu_spoke_i, .hub_o, .hub_ack_i, .hub_rdata_i, .evt_done_o, .evt_half_o);
  hub_mem_model hub (.clk_i, .hub_i(hub_o), .ack_o(hub_ack_i), .rdata_o(hub_rdata_i));
  // ----------------------------------------------------------------
  // clock, cpu noise, event count, watchdog
  // ----------------------------------------------------------------
  always #12.5 clk_i = ~clk_i;
  // random cpu use of random spokes, far below the starve limit
  always @(posedge clk_i) begin
    cpu_req_i <= ($urandom_range(3) == 0);
    cpu_spoke_i <= 3'($urandom_range(7));
  end
  always @(posedge clk_i) n_half <= n_half + $countones(evt_half_o);
  initial begin
    #500000;
    n_mismatch++;
    complete_run();
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [32:0] seen, exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %0t %s: %h vs %h", $time, what, seen, exp);
    end
  endtask : chk
  // one apb transfer, entered just after an edge, waits for ready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin @(posedge clk_i); n++; end while (pready_o !== 1'b1 && n < 20);
    rd = prdata_o;
    er = pslverr_o;
    chk({32'h0, pready_o}, 33'h1, "apb answer");
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask : apb
  task automatic td(input int t, input logic [15:0] s, d, input int n, input logic [31:0] c);
    apb(1'b1, 12'(12'h800 + 16 * t), {16'h0, s});
    apb(1'b1, 12'(12'h804 + 16 * t), {16'h0, d});
    apb(1'b1, 12'(12'h808 + 16 * t), 32'(n));
    apb(1'b1, 12'(12'h80C + 16 * t), c);
  endtask : td
  task automatic wait_done(input int ch);
    int n = 0;
    while (evt_done_o[ch] !== 1'b1 && n < 3000) begin @(posedge clk_i); n++; end
    chk({32'h0, evt_done_o[ch]}, 33'h1, "done event");
  endtask : wait_done
  task automatic add_seg(input int s, input int n);
    for (int a = s; a < s + n; a++) exp_q.push_back(8'(a ^ (a >> 8) ^ 8'h5A));
  endtask : add_seg
  task automatic check_q(input int d);
    for (int i = 0; exp_q.size() > 0; i++)
      chk({25'h0, hub.mem[d + i]}, {25'h0, exp_q.pop_front()}, "moved byte");
  endtask : check_q
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(9675));
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    // reset values, unmapped and misaligned refusals
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk({er, rd}, {re[i], 32'h0}, "register read");
    end
    // random channel settings on the last channel read back whole
    cnt = $urandom & 32'h001F_FF8F;
    apb(1'b1, 12'h15C, 32'(cnt));
    apb(1'b0, 12'h15C, 32'h0);
    chk({er, rd}, {1'b0, 32'(cnt)}, "channel settings");
    apb(1'b1, 12'h15C, 32'h0);
    apb(1'b1, 12'h000, 32'h1);
    // single descriptor, one byte then a random length, rewritten between runs
    for (int k = 0; k < 2; k++) begin
      cnt = (k == 0) ? 1 : $urandom_range(16, 2);
      td(0, 16'h0100, 16'(16'h2100 + 16'h40 * k), cnt, 32'h0F00);
      apb(1'b1, 12'h100, 32'h10);
      apb(1'b1, 12'h008, 32'h1);
      wait_done(0);
      add_seg(16'h0100, cnt);
      check_q(16'h2100 + 16'h40 * k);
      chk(33'(n_half), 33'(cnt > 1), "half events");
    end
    // two linked segments gathered, started by a routed trigger
    td(1, 16'h0200, 16'h4000, 3, 32'h0C82);
    td(2, 16'h0300, 16'h4003, 2, 32'h0D00);
    apb(1'b1, 12'h118, 32'h4092);
    trig_i[6] <= 1'b1;
    repeat (5) @(posedge clk_i);
    trig_i[6] <= 1'b0;
    wait_done(6);
    add_seg(16'h0200, 3);
    add_seg(16'h0300, 2);
    check_q(16'h4000);
    // two channels started together, the more urgent one moves first
    td(3, 16'h0500, 16'h6000, 2, 32'h0D00);
    td(4, 16'h0600, 16'h6100, 2, 32'h0D00);
    apb(1'b1, 12'h108, 32'h195);
    apb(1'b1, 12'h10C, 32'h211);
    apb(1'b1, 12'h008, 32'hC);
    for (cnt = 0; hub_o.req !== 1'b1 && cnt < 200; cnt++) @(posedge clk_i);
    chk({17'h0, hub_o.addr}, {17'h0, 16'h0600}, "first source");
    wait_done(3);
    wait_done(2);
    add_seg(16'h0600, 2);
    check_q(16'h6100);
    add_seg(16'h0500, 2);
    check_q(16'h6000);
    // endless descriptor moves until cancelled
    td(5, 16'h0700, 16'h7000, 0, 32'h0C00);
    apb(1'b1, 12'h110, 32'h290);
    apb(1'b1, 12'h008, 32'h10);
    for (int i = 0; i < 2; i++) begin
      repeat (150) @(posedge clk_i);
      apb(1'b0, 12'h00C, 32'h0);
      chk({er, rd}, {1'b0, i ? 32'h0 : 32'h10}, "run mask");
      apb(1'b1, 12'h110, 32'h2D0);
    end
    complete_run();
  end
endmodule : dma_channel_arbiter_chainer_tb

// ==== testbench/hub_mem_model.sv ====
/*
  Hub partner: byte memory answering each held request after a
  random stall of zero to three cycles.
  Assumes: requests are held until the one-cycle ack.
*/
`timescale 1ns/1ps
module hub_mem_model (
  input  wire logic              clk_i,
  input  wire dma_pkg::hub_req_t hub_i,
  output logic                   ack_o,
  output logic [7:0]             rdata_o
);
  logic [7:0]  mem [0:65535];
  int unsigned dly = 0;
  // ----------------------------------------------------------------
  // memory and answer
  // ----------------------------------------------------------------
  // address-derived fill so a misrouted byte shows
  initial for (int i = 0; i < 65536; i++) mem[i] = 8'(i ^ (i >> 8) ^ 8'h5A);
  // read data only valid with ack, else toggles so stale bytes fail
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (hub_i.req && !ack_o) begin
      if (dly == 0) begin
        ack_o <= 1'b1;
        dly <= $urandom_range(3);
        if (hub_i.we) mem[hub_i.addr] <= hub_i.wdata;
        else rdata_o <= mem[hub_i.addr];
      end else dly <= dly - 1;
    end
  end
endmodule : hub_mem_model
